// ==== design/dpps_pkg.sv ====
package dpps_pkg;
    localparam int          ADDR_W         = 8;
    localparam int          DATA_W         = 8;
    // ground on a jumper gives 0, open gives 1
    localparam logic        JUMPER_GROUND  = 1'h0;
    localparam logic        JUMPER_OPEN    = 1'h1;
    // conventional port addresses
    localparam logic [7:0]  PORT_FLOPPY    = 8'hFD;
    localparam logic [7:0]  PORT_PRINTER   = 8'hF6;
    localparam int          STATUS_FULL_BIT = 0;
    localparam logic [7:0]  RESET_BYTE     = 8'h00;

    typedef enum logic [1:0] {
        DPPS_IDLE  = 2'b00,
        DPPS_BUSY  = 2'b01,
        DPPS_BLOCK = 2'b10
    } dpps_dma_state_t;
endpackage

// ==== design/dpps_port_select.sv ====
`timescale 1ns/10ps
module dpps_port_select (
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic [7:0] address_jumper_socket_i,
    input  wire logic       host_out_cycle_i,
    input  wire logic [7:0] host_addr_i,
    input  wire logic [7:0] host_data_i,
    input  wire logic       local_data_rd_i,
    input  wire logic       dma_req_i,
    input  wire logic       dma_done_i,
    input  wire logic       bus_hold_ack_i,
    input  wire logic       priority_chain_in_i,
    output logic            priority_chain_out_o,
    output logic            dma_grant_o,
    output logic            host_hold_o,
    output logic [7:0]      cmd_data_o,
    output logic [7:0]      cmd_status_o
);

    ////////////////////////////////////////////////////////////////////////
    // port decode

    // a jumper to ground reads low, so the pin level is the bit itself
    function automatic logic [7:0] jumper_addr(input logic [7:0] pins);
        for (int n = 0; n < dpps_pkg::ADDR_W; n++) begin
            jumper_addr[n] = (pins[n] == dpps_pkg::JUMPER_OPEN);
        end
    endfunction

    logic [7:0] port_addr;
    logic       cmd_hit;
    // the FD and F6 conventions are strap choices; no address is hard-wired
    assign port_addr = jumper_addr(address_jumper_socket_i);
    assign cmd_hit   = host_out_cycle_i && (host_addr_i == port_addr);

    ////////////////////////////////////////////////////////////////////////
    // command byte and hold

    logic       full_q, full_d;
    logic [7:0] data_q, data_d;

    always_comb begin
        full_d = full_q;
        data_d = data_q;
        if (local_data_rd_i) begin
            full_d = 1'h0;
        end
        // a new write wins over the read clear; the host is held so this is rare
        if (cmd_hit && !full_q) begin
            full_d = 1'h1;
            data_d = host_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            full_q <= 1'h0;
            data_q <= dpps_pkg::RESET_BYTE;
        end else begin
            full_q <= full_d;
            data_q <= data_d;
        end
    end

    assign host_hold_o  = full_q;
    assign cmd_data_o   = data_q;
    always_comb begin
        cmd_status_o = 8'h00;
        cmd_status_o[dpps_pkg::STATUS_FULL_BIT] = full_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // dma priority

    dpps_pkg::dpps_dma_state_t state_q, state_d;
    logic                      grant_q, grant_d;

    // chain passes on only while this board neither requests nor owns the bus;
    // that first-come ownership also blocks later boards whatever their rank
    assign priority_chain_out_o = priority_chain_in_i && !dma_req_i &&
                                  (state_q == dpps_pkg::DPPS_IDLE);

    always_comb begin
        state_d = state_q;
        grant_d = grant_q;
        unique case (state_q)
            dpps_pkg::DPPS_IDLE: begin
                // another board's hold drops our chain input, so we wait
                if (dma_req_i && priority_chain_in_i) begin
                    state_d = full_q ? dpps_pkg::DPPS_BLOCK : dpps_pkg::DPPS_BUSY;
                    grant_d = 1'h1;
                end
            end
            dpps_pkg::DPPS_BUSY: begin
                if (full_q) begin
                    state_d = dpps_pkg::DPPS_BLOCK;
                end else if (dma_done_i) begin
                    state_d = dpps_pkg::DPPS_IDLE;
                    grant_d = 1'h0;
                end
            end
            dpps_pkg::DPPS_BLOCK: begin
                // host stays held for the whole block until the dummy command is read
                if (!full_q && dma_done_i) begin
                    state_d = dpps_pkg::DPPS_IDLE;
                    grant_d = 1'h0;
                end
            end
            default: begin
                state_d = dpps_pkg::DPPS_IDLE;
                grant_d = 1'h0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            state_q <= dpps_pkg::DPPS_IDLE;
            grant_q <= 1'h0;
        end else begin
            state_q <= state_d;
            grant_q <= grant_d;
        end
    end

    assign dma_grant_o = grant_q;

    ////////////////////////////////////////////////////////////////////////
    // checks

    property p_hit_sets_flag;
        @(posedge clk_i) disable iff (!rst_b_i)
        (cmd_hit && !full_q) |=> (full_q && data_q == $past(host_data_i));
    endproperty
    a_hit_sets_flag: assert property (p_hit_sets_flag)
        else $error("command write lost");

    property p_miss_no_flag;
        @(posedge clk_i) disable iff (!rst_b_i)
        (!full_q && !(host_out_cycle_i && host_addr_i == address_jumper_socket_i))
            |=> !full_q;
    endproperty
    a_miss_no_flag: assert property (p_miss_no_flag)
        else $error("flag set by foreign address");

    property p_hold_until_read;
        @(posedge clk_i) disable iff (!rst_b_i)
        (host_hold_o && !local_data_rd_i) |=> host_hold_o;
    endproperty
    a_hold_until_read: assert property (p_hold_until_read)
        else $error("hold dropped early");

    property p_read_clears;
        @(posedge clk_i) disable iff (!rst_b_i)
        (local_data_rd_i && !cmd_hit) |=> !cmd_status_o[0];
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("status not cleared");

    property p_chain_blocked;
        @(posedge clk_i) disable iff (!rst_b_i)
        dma_req_i |-> !priority_chain_out_o;
    endproperty
    a_chain_blocked: assert property (p_chain_blocked)
        else $error("chain passed while requesting");

    property p_no_grant_without_chain;
        @(posedge clk_i) disable iff (!rst_b_i)
        (!dma_grant_o && !priority_chain_in_i) |=> !dma_grant_o;
    endproperty
    a_no_grant_without_chain: assert property (p_no_grant_without_chain)
        else $error("grant without priority");

    property p_grant_follows_req;
        @(posedge clk_i) disable iff (!rst_b_i)
        (!dma_grant_o && dma_req_i && priority_chain_in_i) |=> dma_grant_o;
    endproperty
    a_grant_follows_req: assert property (p_grant_follows_req)
        else $error("grant missed");

    property p_block_keeps_bus;
        @(posedge clk_i) disable iff (!rst_b_i)
        (dma_grant_o && host_hold_o) |=> (dma_grant_o && !priority_chain_out_o);
    endproperty
    a_block_keeps_bus: assert property (p_block_keeps_bus)
        else $error("block hold lost bus");

    // an idle board must not starve the boards below it
    property p_chain_passes;
        @(posedge clk_i) disable iff (!rst_b_i)
        (priority_chain_in_i && !dma_req_i && !dma_grant_o) |-> priority_chain_out_o;
    endproperty
    a_chain_passes: assert property (p_chain_passes)
        else $error("chain not passed while idle");

    property p_grant_holds;
        @(posedge clk_i) disable iff (!rst_b_i)
        (dma_grant_o && !dma_done_i) |=> dma_grant_o;
    endproperty
    a_grant_holds: assert property (p_grant_holds)
        else $error("grant dropped before done");

    property p_granted_blocks_chain;
        @(posedge clk_i) disable iff (!rst_b_i)
        dma_grant_o |-> !priority_chain_out_o;
    endproperty
    a_granted_blocks_chain: assert property (p_granted_blocks_chain)
        else $error("chain passed while granted");

    property p_held_byte_kept;
        @(posedge clk_i) disable iff (!rst_b_i)
        host_hold_o |=> $stable(cmd_data_o);
    endproperty
    a_held_byte_kept: assert property (p_held_byte_kept)
        else $error("held byte overwritten");

    c_cmd_write: cover property (@(posedge clk_i) cmd_hit ##1 full_q ##[1:20] !full_q);
    c_grant: cover property (@(posedge clk_i) dma_req_i ##1 dma_grant_o ##[1:20] !dma_grant_o);
    c_block: cover property (@(posedge clk_i) (dma_grant_o && host_hold_o) ##[1:20] !dma_grant_o);
endmodule

// ==== verification/dpps_upper_board.sv ====
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// board ranked just above the device in the priority chain
module dpps_upper_board (
    input  wire logic req_i,
    output logic      chain_o
);
    // priority passes down only while this board is not requesting
    assign chain_o = !req_i;
endmodule

// ==== verification/dpps_port_select_tb.sv ====
`timescale 1ns/10ps
module dpps_port_select_tb;
    logic       clk = 1'h0, rst_b = 1'h0, out_c = 1'h0, rd = 1'h0;
    logic       req = 1'h0, done = 1'h0, up_req = 1'h0, ch_in, ch_out, grant, hold;
    logic [7:0] jmp = 8'hFD, adr = 8'h00, dat = 8'h00, cdat, stat;
    int         error_cnt = 0, check_count = 0;
    // decode rows: jumpers, host address, accepted
    logic [7:0] jmp_tbl [6] = '{8'hFD, 8'hF6, 8'hFD, 8'hF6, 8'h01, 8'h01};
    logic [7:0] adr_tbl [6] = '{8'hFD, 8'hF6, 8'hFC, 8'h76, 8'h01, 8'h80};
    logic       ok_tbl  [6] = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0};
    ////////////////////////////////////////////////////////////////////////////
    initial forever #10 clk = ~clk;
    dpps_upper_board upper (.req_i(up_req), .chain_o(ch_in));
    dpps_port_select dut (.clk_i(clk), .rst_b_i(rst_b), .address_jumper_socket_i(jmp),
        .host_out_cycle_i(out_c), .host_addr_i(adr), .host_data_i(dat),
        .local_data_rd_i(rd), .dma_req_i(req), .dma_done_i(done), .bus_hold_ack_i(1'h0),
        .priority_chain_in_i(ch_in), .priority_chain_out_o(ch_out), .dma_grant_o(grant),
        .host_hold_o(hold), .cmd_data_o(cdat), .cmd_status_o(stat));
    ////////////////////////////////////////////////////////////////////////////
    task chk(input logic ok, input string m);
        check_count++;
        if (ok !== 1'h1) begin
            error_cnt++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task wr(input logic [7:0] j, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        out_c <= 1'h1;
        jmp   <= j;
        adr   <= a;
        dat   <= d;
        @(posedge clk);
        out_c <= 1'h0;
        #1;
    endtask
    task rd_cmd;
        @(posedge clk);
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1;
    endtask
    task done_p(input logic keep);
        @(posedge clk);
        done <= 1'h1;
        @(posedge clk);
        done <= 1'h0;
        req  <= keep;
        #1;
    endtask
    task end_sim;
        if (error_cnt == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // hang guard: whole run is well under a hundred cycles, limit is 2000
    initial begin
        #40000;
        error_cnt++;
        end_sim();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'h1;
        #1;
        chk(hold === 1'h0 && grant === 1'h0 && stat === 8'h00, "reset state");
        for (int i = 0; i < 6; i++) begin
            wr(jmp_tbl[i], adr_tbl[i], 8'h3C ^ 8'(i));
            chk(hold === ok_tbl[i], "decode");
            chk(stat === {7'h00, ok_tbl[i]}, "status");
            if (ok_tbl[i]) begin
                chk(cdat === (8'h3C ^ 8'(i)), "command byte");
                rd_cmd();
                chk(hold === 1'h0 && stat === 8'h00, "release after read");
            end
        end
        // a second write while held is refused and the first byte kept
        wr(8'hFD, 8'hFD, 8'h55);
        wr(8'hFD, 8'hFD, 8'hAA);
        chk(hold === 1'h1 && cdat === 8'h55, "held write");
        rd_cmd();
        // plain grant; a later request from the upper board must wait
        @(posedge clk);
        req <= 1'h1;
        @(posedge clk);
        up_req <= 1'h1;
        #1;
        chk(grant === 1'h1 && ch_out === 1'h0, "grant");
        repeat (2) @(posedge clk);
        #1;
        chk(grant === 1'h1, "grant kept");
        done_p(1'h0);
        @(posedge clk);
        up_req <= 1'h0;
        #1;
        chk(grant === 1'h0 && ch_out === 1'h1, "grant end");
        // upper board first: wait until it lets go
        @(posedge clk);
        up_req <= 1'h1;
        req    <= 1'h1;
        repeat (4) @(posedge clk);
        #1;
        chk(grant === 1'h0, "no grant without chain");
        @(posedge clk);
        up_req <= 1'h0;
        @(posedge clk);
        #1;
        chk(grant === 1'h1, "grant after upper");
        done_p(1'h0);
        // block transfer: grant stays while host is held
        wr(8'hFD, 8'hFD, 8'h11);
        @(posedge clk);
        req <= 1'h1;
        @(posedge clk);
        #1;
        chk(grant === 1'h1, "block grant");
        done_p(1'h1);
        chk(grant === 1'h1 && ch_out === 1'h0, "block hold");
        rd_cmd();
        done_p(1'h0);
        chk(grant === 1'h0 && hold === 1'h0, "block end");
        // reset in mid-run drops a held byte and a fresh grant
        wr(8'hFD, 8'hFD, 8'h22);
        @(posedge clk);
        req <= 1'h1;
        @(posedge clk);
        rst_b <= 1'h0;
        req   <= 1'h0;
        repeat (2) @(posedge clk);
        rst_b <= 1'h1;
        #1;
        chk(hold === 1'h0 && grant === 1'h0 && stat === 8'h00, "reset again");
        chk(cdat === dpps_pkg::RESET_BYTE && ch_out === 1'h1, "reset outputs");
        wr(8'hFD, 8'hFD, 8'h33);
        chk(hold === 1'h1 && cdat === 8'h33, "write after reset");
        rd_cmd();
        end_sim();
    end
endmodule
